// file: design/fsf_map.vh
// Purpose: offsets, fields, reset values and timing for the fail-safe
//          flag and configuration register group
// Assumes: byte addresses on a 32-bit register bus
// Notes:   definitions only
`ifndef FSF_MAP_VH
`define FSF_MAP_VH

`define FSF_ADDR_W            8
`define FSF_OFF_SUMMARY       8'h00
`define FSF_OFF_REACT_CORE_IO 8'h04
`define FSF_OFF_REACT_AUX     8'h08
`define FSF_OFF_SSM_CFG       8'h0c
`define FSF_OFF_IRQ_STATUS    8'h10
`define FSF_OFF_IRQ_MASK      8'h14

`define FSF_BIT_COMM_SUM      23
`define FSF_BIT_PIN_SUM       21
`define FSF_BIT_SUPPLY_SUM    20
`define FSF_BIT_PULSE_SEL     17
`define FSF_BIT_TIMER_DIS     12
`define FSF_LSB_HI_PAIR_A     22
`define FSF_LSB_HI_PAIR_B     20
`define FSF_LSB_LO_PAIR_A     10
`define FSF_LSB_LO_PAIR_B     8
`define FSF_LSB_CNT_LIMIT     22
`define FSF_LSB_CNT_VALUE     8

`define FSF_RST_CORE_OV       2'h3
`define FSF_RST_CORE_UV       2'h0
`define FSF_RST_IO_OV         2'h3
`define FSF_RST_IO_UV         2'h1
`define FSF_RST_AUX_OV        2'h3
`define FSF_RST_AUX_UV        2'h1
`define FSF_RST_CNT_LIMIT     2'h1
`define FSF_RST_PULSE_SEL     1'b0
`define FSF_RST_TIMER_DIS     1'b0

`define FSF_IRQ_W             4
`define FSF_IRQ_COMM          0
`define FSF_IRQ_PIN           1
`define FSF_IRQ_SUPPLY        2
`define FSF_IRQ_PULSE_DONE    3

`define FSF_RESP_OKAY         2'h0
`define FSF_RESP_SLVERR       2'h2

`define FSF_CLK_PERIOD_NS     4
`define FSF_PULSE_LONG_US     10000
`define FSF_PULSE_SHORT_US    1000
// worked in ns so the product stays inside 32-bit integer range
`define FSF_PULSE_LONG_CYC    (`FSF_PULSE_LONG_US * 1000 / `FSF_CLK_PERIOD_NS)
`define FSF_PULSE_SHORT_CYC   (`FSF_PULSE_SHORT_US * 1000 / `FSF_CLK_PERIOD_NS)

`endif

// file: design/fsf_pulse_timer.v
// Purpose: timed low pulse for the reset output pin
// Assumes: start is a level or pulse synchronous to aclk
// Notes:   a start while a pulse runs is ignored
`timescale 1ns/1ps
module fsf_pulse_timer #(
  parameter CW        = 22,
  parameter LONG_CYC  = 2500000,
  parameter SHORT_CYC = 250000
) (
  input  wire          aclk,
  input  wire          aresetn,
  input  wire          ce,
  input  wire          start,
  input  wire          sel_short,
  output reg           active_q,
  output reg           done_q
);

  reg  [CW-1:0] cnt_q;
  wire [CW-1:0] long_ld;
  wire [CW-1:0] short_ld;
  wire [31:0]   long_full;
  wire [31:0]   short_full;

  // load counts minus one so the pulse lasts exactly the selected cycles
  assign long_full  = LONG_CYC - 1;
  assign short_full = SHORT_CYC - 1;
  assign long_ld    = long_full[CW-1:0];
  assign short_ld   = short_full[CW-1:0];

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cnt_q    <= {CW{1'b0}};
      active_q <= 1'b0;
      done_q   <= 1'b0;
    end
    else if (ce)
    begin
      done_q <= 1'b0;
      if (!active_q)
      begin
        if (start)
        begin
          cnt_q    <= sel_short ? short_ld : long_ld;
          active_q <= 1'b1;
        end
      end
      else if (cnt_q == {CW{1'b0}})
      begin
        active_q <= 1'b0;
        done_q   <= 1'b1;
      end
      else
      begin
        cnt_q <= cnt_q - {{(CW-1){1'b0}}, 1'b1};
      end
    end
  end

endmodule // fsf_pulse_timer

// file: design/fsf_regs.v
// Purpose: fail-safe summary flags and configuration registers
// Assumes: fault inputs synchronous to aclk; aresetn is power-on reset
// Notes:   AXI4-Lite slave, one outstanding read and one write
// Function
// - Bit 23 of the summary register is the OR of the bus CRC and bus request errors.
// - Bit 21 is the OR of the power-good pin and reset pin diagnostics.
// - Bit 20 is the OR of the six core, I/O and aux over/undervoltage bits.
// - Summary bits follow their inputs live and clear only when all inputs clear.
// - Pulse select bit 17 gives a 10 ms reset pulse at 0, 1.0 ms at 1, reset only at power-on.
//
// Added by the designer: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/1ps
`include "fsf_map.vh"
module fsf_regs #(
  parameter CW        = 22,
  parameter LONG_CYC  = `FSF_PULSE_LONG_CYC,
  parameter SHORT_CYC = `FSF_PULSE_SHORT_CYC
) (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire        ce,
  input  wire [7:0]  s_axi_awaddr,
  input  wire [2:0]  s_axi_awprot,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [7:0]  s_axi_araddr,
  input  wire [2:0]  s_axi_arprot,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  input  wire        bus_crc_error,
  input  wire        bus_request_error,
  input  wire        power_good_pin_diag,
  input  wire        reset_pin_diag,
  input  wire        core_monitor_overvoltage,
  input  wire        core_monitor_undervoltage,
  input  wire        io_supply_overvoltage,
  input  wire        io_supply_undervoltage,
  input  wire        aux_monitor_overvoltage,
  input  wire        aux_monitor_undervoltage,
  input  wire [3:0]  fault_counter_value,
  input  wire        reset_pulse_request,
  output wire        comm_fault_summary,
  output wire        safety_pin_fault_summary,
  output wire        supply_monitor_fault_summary,
  output reg  [1:0]  core_ov_reaction,
  output reg  [1:0]  core_uv_reaction,
  output reg  [1:0]  io_ov_reaction,
  output reg  [1:0]  io_uv_reaction,
  output reg  [1:0]  aux_ov_reaction,
  output reg  [1:0]  aux_uv_reaction,
  output reg  [1:0]  fault_counter_limit,
  output reg         reset_pulse_width_sel,
  output reg         reset_low_timer_disable,
  output wire        reset_output_pin_n,
  output wire        irq
);

  localparam IW = `FSF_IRQ_W;

  reg  [7:0]    awaddr_q;
  reg           aw_hold_q;
  reg  [31:0]   wdata_q;
  reg  [3:0]    wstrb_q;
  reg           w_hold_q;
  wire          do_wr;
  wire          ar_take;
  reg           wr_hit;
  reg  [31:0]   rd_word;
  reg           rd_hit;
  reg  [IW-1:0] irq_status_q;
  reg  [IW-1:0] irq_status_d;
  reg  [IW-1:0] irq_mask_q;
  reg  [IW-1:0] event_vec;
  reg  [2:0]    sum_prev_q;
  wire [2:0]    sum_now;
  wire          pulse_active;
  wire          pulse_done;
  wire          wr_lane1;
  wire          wr_lane2;
  wire          wr_lane0;

  // live summaries straight from the individual fault bits
  assign comm_fault_summary = bus_crc_error | bus_request_error;
  assign safety_pin_fault_summary =
    power_good_pin_diag | reset_pin_diag;
  assign supply_monitor_fault_summary =
    core_monitor_overvoltage | core_monitor_undervoltage |
    io_supply_overvoltage | io_supply_undervoltage |
    aux_monitor_overvoltage | aux_monitor_undervoltage;

  assign sum_now = {supply_monitor_fault_summary,
                    safety_pin_fault_summary,
                    comm_fault_summary};

  // readies drop while ce is low so no beat is taken and then frozen
  assign s_axi_awready = ce & ~aw_hold_q;
  assign s_axi_wready  = ce & ~w_hold_q;
  assign s_axi_arready = ce & ~s_axi_rvalid;
  assign do_wr   = aw_hold_q & w_hold_q & ~s_axi_bvalid;
  assign ar_take = s_axi_arvalid & s_axi_arready;

  assign wr_lane0 = do_wr & wstrb_q[0];
  assign wr_lane1 = do_wr & wstrb_q[1];
  assign wr_lane2 = do_wr & wstrb_q[2];

  always @*
  begin
    case (awaddr_q)
      `FSF_OFF_SUMMARY:       wr_hit = 1'b1;
      `FSF_OFF_REACT_CORE_IO: wr_hit = 1'b1;
      `FSF_OFF_REACT_AUX:     wr_hit = 1'b1;
      `FSF_OFF_SSM_CFG:       wr_hit = 1'b1;
      `FSF_OFF_IRQ_STATUS:    wr_hit = 1'b1;
      `FSF_OFF_IRQ_MASK:      wr_hit = 1'b1;
      default:                wr_hit = 1'b0;
    endcase
  end

  // address and data may arrive in either order; each is held alone
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      awaddr_q     <= 8'h00;
      aw_hold_q    <= 1'b0;
      wdata_q      <= 32'h00000000;
      wstrb_q      <= 4'h0;
      w_hold_q     <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `FSF_RESP_OKAY;
    end
    else if (ce)
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        awaddr_q  <= {s_axi_awaddr[7:2], 2'b00};
        aw_hold_q <= 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        wdata_q  <= s_axi_wdata;
        wstrb_q  <= s_axi_wstrb;
        w_hold_q <= 1'b1;
      end
      if (do_wr)
      begin
        aw_hold_q    <= 1'b0;
        w_hold_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_hit ? `FSF_RESP_OKAY : `FSF_RESP_SLVERR;
      end
      else if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // configuration fields; only the named field bits are stored
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      core_ov_reaction        <= `FSF_RST_CORE_OV;
      core_uv_reaction        <= `FSF_RST_CORE_UV;
      io_ov_reaction          <= `FSF_RST_IO_OV;
      io_uv_reaction          <= `FSF_RST_IO_UV;
      aux_ov_reaction         <= `FSF_RST_AUX_OV;
      aux_uv_reaction         <= `FSF_RST_AUX_UV;
      fault_counter_limit     <= `FSF_RST_CNT_LIMIT;
      reset_pulse_width_sel   <= `FSF_RST_PULSE_SEL;
      reset_low_timer_disable <= `FSF_RST_TIMER_DIS;
      irq_mask_q              <= {IW{1'b0}};
    end
    else if (ce)
    begin
      case (awaddr_q)
        `FSF_OFF_REACT_CORE_IO:
        begin
          if (wr_lane2)
          begin
            core_ov_reaction <=
              wdata_q[`FSF_LSB_HI_PAIR_A+1:`FSF_LSB_HI_PAIR_A];
            core_uv_reaction <=
              wdata_q[`FSF_LSB_HI_PAIR_B+1:`FSF_LSB_HI_PAIR_B];
          end
          if (wr_lane1)
          begin
            io_ov_reaction <=
              wdata_q[`FSF_LSB_LO_PAIR_A+1:`FSF_LSB_LO_PAIR_A];
            io_uv_reaction <=
              wdata_q[`FSF_LSB_LO_PAIR_B+1:`FSF_LSB_LO_PAIR_B];
          end
        end
        `FSF_OFF_REACT_AUX:
        begin
          if (wr_lane1)
          begin
            aux_ov_reaction <=
              wdata_q[`FSF_LSB_LO_PAIR_A+1:`FSF_LSB_LO_PAIR_A];
            aux_uv_reaction <=
              wdata_q[`FSF_LSB_LO_PAIR_B+1:`FSF_LSB_LO_PAIR_B];
          end
        end
        `FSF_OFF_SSM_CFG:
        begin
          if (wr_lane2)
          begin
            fault_counter_limit <=
              wdata_q[`FSF_LSB_CNT_LIMIT+1:`FSF_LSB_CNT_LIMIT];
            reset_pulse_width_sel <= wdata_q[`FSF_BIT_PULSE_SEL];
          end
          if (wr_lane1)
          begin
            // counter value bits are read-only and dropped here
            reset_low_timer_disable <= wdata_q[`FSF_BIT_TIMER_DIS];
          end
        end
        `FSF_OFF_IRQ_MASK:
        begin
          if (wr_lane0)
          begin
            irq_mask_q <= wdata_q[IW-1:0];
          end
        end
        default:
        begin
          // summary, status and unmapped words store nothing here
          irq_mask_q <= irq_mask_q;
        end
      endcase
    end
  end

  // rising edge of a summary or an ended pulse is an interrupt event
  always @*
  begin
    event_vec = {IW{1'b0}};
    event_vec[`FSF_IRQ_COMM]   = sum_now[0] & ~sum_prev_q[0];
    event_vec[`FSF_IRQ_PIN]    = sum_now[1] & ~sum_prev_q[1];
    event_vec[`FSF_IRQ_SUPPLY] = sum_now[2] & ~sum_prev_q[2];
    event_vec[`FSF_IRQ_PULSE_DONE] = pulse_done;
    irq_status_d = irq_status_q;
    if (wr_lane0 && awaddr_q == `FSF_OFF_IRQ_STATUS)
    begin
      irq_status_d = irq_status_q & ~wdata_q[IW-1:0];
    end
    // a new event wins over a clear in the same cycle
    irq_status_d = irq_status_d | event_vec;
  end

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      irq_status_q <= {IW{1'b0}};
      sum_prev_q   <= 3'b000;
    end
    else if (ce)
    begin
      irq_status_q <= irq_status_d;
      sum_prev_q   <= sum_now;
    end
  end

  assign irq = |(irq_status_q & irq_mask_q);

  // read word assembly; reserved bits read as zero
  always @*
  begin
    rd_word = 32'h00000000;
    rd_hit  = 1'b1;
    case ({s_axi_araddr[7:2], 2'b00})
      `FSF_OFF_SUMMARY:
      begin
        rd_word[`FSF_BIT_COMM_SUM]   = comm_fault_summary;
        rd_word[`FSF_BIT_PIN_SUM]    = safety_pin_fault_summary;
        rd_word[`FSF_BIT_SUPPLY_SUM] = supply_monitor_fault_summary;
      end
      `FSF_OFF_REACT_CORE_IO:
      begin
        rd_word[`FSF_LSB_HI_PAIR_A+1:`FSF_LSB_HI_PAIR_A] = core_ov_reaction;
        rd_word[`FSF_LSB_HI_PAIR_B+1:`FSF_LSB_HI_PAIR_B] = core_uv_reaction;
        rd_word[`FSF_LSB_LO_PAIR_A+1:`FSF_LSB_LO_PAIR_A] = io_ov_reaction;
        rd_word[`FSF_LSB_LO_PAIR_B+1:`FSF_LSB_LO_PAIR_B] = io_uv_reaction;
      end
      `FSF_OFF_REACT_AUX:
      begin
        rd_word[`FSF_LSB_LO_PAIR_A+1:`FSF_LSB_LO_PAIR_A] = aux_ov_reaction;
        rd_word[`FSF_LSB_LO_PAIR_B+1:`FSF_LSB_LO_PAIR_B] = aux_uv_reaction;
      end
      `FSF_OFF_SSM_CFG:
      begin
        rd_word[`FSF_LSB_CNT_LIMIT+1:`FSF_LSB_CNT_LIMIT] =
          fault_counter_limit;
        rd_word[`FSF_BIT_PULSE_SEL] = reset_pulse_width_sel;
        rd_word[`FSF_BIT_TIMER_DIS] = reset_low_timer_disable;
        rd_word[`FSF_LSB_CNT_VALUE+3:`FSF_LSB_CNT_VALUE] =
          fault_counter_value;
      end
      `FSF_OFF_IRQ_STATUS:
      begin
        rd_word[IW-1:0] = irq_status_q;
      end
      `FSF_OFF_IRQ_MASK:
      begin
        rd_word[IW-1:0] = irq_mask_q;
      end
      default:
      begin
        rd_hit = 1'b0;
      end
    endcase
  end

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= `FSF_RESP_OKAY;
    end
    else if (ce)
    begin
      if (ar_take)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_word;
        s_axi_rresp  <= rd_hit ? `FSF_RESP_OKAY : `FSF_RESP_SLVERR;
      end
      else if (s_axi_rvalid && s_axi_rready)
      begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // pulse length follows the select bit at the moment of the request
  fsf_pulse_timer #(
    .CW        (CW),
    .LONG_CYC  (LONG_CYC),
    .SHORT_CYC (SHORT_CYC)
  ) u_pulse (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .ce        (ce),
    .start     (reset_pulse_request),
    .sel_short (reset_pulse_width_sel),
    .active_q  (pulse_active),
    .done_q    (pulse_done)
  );

  assign reset_output_pin_n = ~pulse_active;

endmodule // fsf_regs

// file: bench/fsf_regs_sva.sv
// Purpose: port checks for the fail-safe flag register group
// Assumes: sim parameters LONG_CYC=20, SHORT_CYC=5
// Notes:   pulse figures are literal, so they track those values
`timescale 1ns/1ps
module fsf_regs_sva #(
  parameter CW        = 8,
  parameter LONG_CYC  = 20,
  parameter SHORT_CYC = 5
) (
  input logic        aclk,
  input logic        aresetn,
  input logic [7:0]  s_axi_araddr,
  input logic        s_axi_arvalid,
  input logic        s_axi_arready,
  input logic [31:0] s_axi_rdata,
  input logic        s_axi_rvalid,
  input logic        bus_crc_error,
  input logic        bus_request_error,
  input logic        power_good_pin_diag,
  input logic        reset_pin_diag,
  input logic        core_monitor_overvoltage,
  input logic        core_monitor_undervoltage,
  input logic        io_supply_overvoltage,
  input logic        io_supply_undervoltage,
  input logic        aux_monitor_overvoltage,
  input logic        aux_monitor_undervoltage,
  input logic        comm_fault_summary,
  input logic        safety_pin_fault_summary,
  input logic        supply_monitor_fault_summary,
  input logic        reset_output_pin_n,
  input logic        reset_pulse_width_sel
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_comm_or:
  assert property (comm_fault_summary == (bus_crc_error | bus_request_error))
    else $error("comm summary wrong");
  a_pin_or:
  assert property (safety_pin_fault_summary ==
    (power_good_pin_diag | reset_pin_diag)) else $error("pin summary wrong");
  a_supply_or:
  assert property (supply_monitor_fault_summary == (core_monitor_overvoltage
    | core_monitor_undervoltage | io_supply_overvoltage
    | io_supply_undervoltage | aux_monitor_overvoltage
    | aux_monitor_undervoltage)) else $error("supply summary wrong");
  a_pin_clear:
  assert property ($fell(safety_pin_fault_summary) |-> !power_good_pin_diag
    && !reset_pin_diag) else $error("pin summary fell early");
  a_pulse_short:
  assert property ($fell(reset_output_pin_n) && $past(reset_pulse_width_sel)
    |-> !reset_output_pin_n [*5] ##1 reset_output_pin_n)
    else $error("short pulse length wrong");
  a_pulse_long:
  assert property ($fell(reset_output_pin_n) && !$past(reset_pulse_width_sel)
    |-> ##19 !reset_output_pin_n ##1 reset_output_pin_n)
    else $error("long pulse length wrong");
  a_rd_next:
  assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_sum_read:
  assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr[7:2] == 0
    |=> s_axi_rdata == {8'h00, $past(comm_fault_summary), 1'b0,
    $past(safety_pin_fault_summary), $past(supply_monitor_fault_summary),
    20'h00000}) else $error("summary word wrong");
endmodule // fsf_regs_sva
bind fsf_regs fsf_regs_sva #(.CW(CW), .LONG_CYC(LONG_CYC),
  .SHORT_CYC(SHORT_CYC)) fsf_regs_sva_inst (.aclk(aclk), .aresetn(aresetn),
  .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rvalid(s_axi_rvalid), .bus_crc_error(bus_crc_error),
  .bus_request_error(bus_request_error),
  .power_good_pin_diag(power_good_pin_diag), .reset_pin_diag(reset_pin_diag),
  .core_monitor_overvoltage(core_monitor_overvoltage),
  .core_monitor_undervoltage(core_monitor_undervoltage),
  .io_supply_overvoltage(io_supply_overvoltage),
  .io_supply_undervoltage(io_supply_undervoltage),
  .aux_monitor_overvoltage(aux_monitor_overvoltage),
  .aux_monitor_undervoltage(aux_monitor_undervoltage),
  .comm_fault_summary(comm_fault_summary),
  .safety_pin_fault_summary(safety_pin_fault_summary),
  .supply_monitor_fault_summary(supply_monitor_fault_summary),
  .reset_output_pin_n(reset_output_pin_n),
  .reset_pulse_width_sel(reset_pulse_width_sel));

// file: bench/fsf_regs_tb.sv
// Purpose: self-checking bench for the fail-safe flag register group
// Assumes: short pulse counts, ce dropped once early on
// Notes:   irq status bits 0..2 stay masked during the flag sweep
`timescale 1ns/1ps
`include "fsf_map.vh"
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin n_mismatch++; \
  $display("unexpected at %0t: %h %h", $time, (a), (b)); end end
module fsf_regs_tb;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid, rpr;
  logic        comm_s, pin_s, sup_s, pin_n, sel, irq;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, d;
  logic [1:0]  bresp, rresp, r;
  logic [9:0]  f, v;
  logic        ce;
  logic [3:0]  wstrb, fcv;
  int          n_mismatch, n_tests;
  fsf_regs #(.CW(8), .LONG_CYC(20), .SHORT_CYC(5)) fsf_regs_inst (
    .aclk(aclk), .aresetn(aresetn), .ce(ce),
    .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .bus_crc_error(f[0]), .bus_request_error(f[1]),
    .power_good_pin_diag(f[2]), .reset_pin_diag(f[3]),
    .core_monitor_overvoltage(f[4]), .core_monitor_undervoltage(f[5]),
    .io_supply_overvoltage(f[6]), .io_supply_undervoltage(f[7]),
    .aux_monitor_overvoltage(f[8]), .aux_monitor_undervoltage(f[9]),
    .fault_counter_value(fcv), .reset_pulse_request(rpr),
    .comm_fault_summary(comm_s), .safety_pin_fault_summary(pin_s),
    .supply_monitor_fault_summary(sup_s), .core_ov_reaction(),
    .core_uv_reaction(), .io_ov_reaction(), .io_uv_reaction(),
    .aux_ov_reaction(), .aux_uv_reaction(), .fault_counter_limit(),
    .reset_pulse_width_sel(sel), .reset_low_timer_disable(),
    .reset_output_pin_n(pin_n), .irq(irq));
  task automatic conclude();
    if (n_mismatch == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  function automatic logic [31:0] exp_sum(logic [9:0] x);
    exp_sum = {8'h00, |x[1:0], 1'b0, |x[3:2], |x[9:4], 20'h00000};
  endfunction
  task automatic wr(input logic [7:0] a, input logic [31:0] w);
    int n;
    n = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= w;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      n++;
    end while (!bvalid && n < 50);
    r = bresp;
    bready <= 1'b0;
    if (!bvalid)
    begin
      n_mismatch++;
      conclude();
    end
  endtask
  task automatic rd(input logic [7:0] a);
    int n;
    n = 0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      n++;
    end while (!rvalid && n < 50);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    if (!rvalid)
    begin
      n_mismatch++;
      conclude();
    end
  endtask
  // reset value, then what survives an all-ones write
  task automatic t_regs();
    logic [31:0] rv [3];
    logic [31:0] wv [3];
    rv = '{32'h00c00d00, 32'h00000d00, 32'h00400500};
    wv = '{32'h00f00f00, 32'h00000f00, 32'h00c21500};
    wr(8'h00, 32'hffffffff);
    `CHK(r, `FSF_RESP_OKAY)
    rd(8'h00);
    `CHK(d, 32'h00000000)
    for (int i = 0; i < 3; i++)
    begin
      rd(8'h04 + 8'(4 * i));
      `CHK(d, rv[i])
      wr(8'h04 + 8'(4 * i), 32'hffffffff);
      rd(8'h04 + 8'(4 * i));
      `CHK(d, wv[i])
    end
    wr(8'h20, 32'h0);
    `CHK(r, `FSF_RESP_SLVERR)
    rd(8'h20);
    `CHK({d, r}, {32'h0, `FSF_RESP_SLVERR})
    // lane 2 only: core pairs cleared, i/o pairs kept
    wstrb <= 4'h4;
    wr(8'h04, 32'h0);
    wstrb <= 4'hf;
    rd(8'h04);
    `CHK(d, 32'h00000f00)
  endtask
  // one-hot sweep, then faults dropped one at a time
  task automatic t_flags();
    for (int i = 0; i < 21; i++)
    begin
      v = (i < 10) ? 10'h001 << i : 10'h3ff << (i - 10);
      f <= v;
      rd(8'h00);
      `CHK(d, exp_sum(v))
      `CHK({comm_s, pin_s, sup_s}, {v[1] | v[0], |v[3:2], |v[9:4]})
    end
    // each summary rose at least once; clear them all by writing ones
    rd(8'h10);
    `CHK(d, 32'h00000007)
    wr(8'h10, 32'h7);
    rd(8'h10);
    `CHK(d, 32'h00000000)
  endtask
  task automatic t_pulse(input logic s, input int len);
    int n;
    n = 0;
    fcv <= {1'b0, s, 2'b11};
    wr(8'h0c, {14'h0, s, 17'h0});
    rd(8'h0c);
    `CHK(d, {14'h0, s, 5'h0, 1'b0, s, 2'b11, 8'h00})
    @(posedge aclk);
    rpr <= 1'b1;
    @(posedge aclk);
    rpr <= 1'b0;
    do
    begin
      @(posedge aclk);
      n++;
    end while (!pin_n && n < 100);
    `CHK(n - 1, len)
    repeat (2) @(posedge aclk);
    `CHK(irq, 1'b0)
    wr(8'h14, 32'h8);
    `CHK(irq, 1'b1)
    wr(8'h10, 32'h8);
    `CHK(irq, 1'b0)
    wr(8'h14, 32'h0);
  endtask
  // frozen enable: no beat taken, a fault edge is kept until it runs again
  task automatic t_ce();
    @(posedge aclk);
    ce <= 1'b0;
    f <= 10'h001;
    repeat (3) @(posedge aclk);
    `CHK({awready, wready, arready}, 3'b000)
    `CHK(comm_s, 1'b1)
    ce <= 1'b1;
    rd(8'h10);
    `CHK(d, 32'h00000001)
    wr(8'h10, 32'h1);
    f <= 10'h000;
  endtask
  initial
  begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end
  initial
  begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, rpr} = 7'h00;
    {awaddr, araddr, wdata, f} = 58'h0;
    ce = 1'b1;
    wstrb = 4'hf;
    fcv = 4'h5;
    n_mismatch = 0;
    n_tests = 0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    t_ce();
    t_regs();
    t_pulse(1'b1, 5);
    t_pulse(1'b0, 20);
    t_flags();
    conclude();
  end
endmodule // fsf_regs_tb
